// ### rtl/cts_params.svh
// timing constants of the instruction timing sequencer
//
// How it works
// - each instruction yields a clock total plus read and write counts
// - flagged classes add the effective address clocks, reads and writes
// - multi-precision figures include operand fetch, store and prefetch
// - register block moves add 8 clocks per register word, 16 long
// - index register size never changes execution time
// - exception figures include stacking, vector and handler fetch
// - interrupt takes at least 72 clocks, 9 reads, 16 writes
// - after reset and halt release, 64 clocks, 12 reads precede execution
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH
// ------------------------------------------------------------------
// bus cycle
// ------------------------------------------------------------------
`define CTS_BUS_CLKS      4
`define CTS_WAIT_PHASE    2
// ------------------------------------------------------------------
// per-class figures: clocks, reads, writes
// ------------------------------------------------------------------
`define CTS_NOP_CLK       16'h0008
`define CTS_NOP_RD        8'h02
`define CTS_MM_M2R_CLK    16'h0018
`define CTS_MM_M2R_RD     8'h06
`define CTS_MM_R2M_CLK    16'h0010
`define CTS_MM_R2M_RD     8'h04
`define CTS_MM_CLK_W      16'h0008
`define CTS_MM_CLK_L      16'h0010
`define CTS_MM_XFR_W      8'h02
`define CTS_MM_XFR_L      8'h04
`define CTS_ADDX_B        {16'h0016, 8'h04, 8'h01}
`define CTS_ADDX_W        {16'h0032, 8'h06, 8'h02}
`define CTS_ADDX_L        {16'h003a, 8'h0a, 8'h04}
`define CTS_CMPM_B        {16'h0010, 8'h04, 8'h00}
`define CTS_CMPM_W        {16'h0018, 8'h06, 8'h00}
`define CTS_CMPM_L        {16'h0028, 8'h0a, 8'h00}
`define CTS_BTST_MEM      {16'h0008, 8'h02, 8'h00}
`define CTS_CHK           {16'h0044, 8'h08, 8'h06}
`define CTS_DIV_ZERO      {16'h0042, 8'h08, 8'h06}
`define CTS_TRAP          {16'h003e, 8'h08, 8'h06}
`define CTS_BUS_ERR       {16'h005e, 8'h08, 8'h0e}
`define CTS_INTERRUPT     {16'h0048, 8'h09, 8'h10}
`define CTS_RESET_SEQ     {16'h0040, 8'h0c, 8'h00}
`endif

// ### rtl/cts_pkg.sv
// types and lookup functions of the instruction timing sequencer
`include "cts_params.svh"
package cts_pkg;
    typedef enum logic [3:0] {
        CLS_NOP, CLS_MOVE_MULTIPLE_REGISTERS_M2R, CLS_MOVE_MULTIPLE_REGISTERS_R2M, CLS_ADDX_MEM, CLS_CMPM,
        CLS_BTST_MEM, CLS_CHK, CLS_DIV_ZERO, CLS_TRAP, CLS_BUS_ERR,
        CLS_INTERRUPT, CLS_RESET
    } cts_class_e;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cts_size_e;
    typedef struct packed {
        logic [15:0] clk;
        logic [7:0]  rd;
        logic [7:0]  wr;
    } cts_tim_s;

    // base figures plus per-register and effective address add-ons
    function automatic cts_tim_s cts_timing(
        input cts_class_e c,
        input cts_size_e  sz,
        input logic [4:0] n,
        input logic       idx_long,
        input logic [7:0] ea_clk,
        input logic [7:0] ea_rd,
        input logic [7:0] ea_wr);
        cts_tim_s t;
        logic     ea;
        logic     lng;
        t   = '0;
        ea  = 1'b0;
        lng = (sz == SZ_LONG);
        // idx_long is deliberately not looked at
        case (c)
            CLS_NOP:       t = {`CTS_NOP_CLK, `CTS_NOP_RD, 8'h00};
            CLS_MOVE_MULTIPLE_REGISTERS_M2R:
            begin
                t.clk = `CTS_MM_M2R_CLK + 16'(n)
                      * (lng ? `CTS_MM_CLK_L : `CTS_MM_CLK_W);
                t.rd  = `CTS_MM_M2R_RD + 8'(n)
                      * (lng ? `CTS_MM_XFR_L : `CTS_MM_XFR_W);
            end
            CLS_MOVE_MULTIPLE_REGISTERS_R2M:
            begin
                t.clk = `CTS_MM_R2M_CLK + 16'(n)
                      * (lng ? `CTS_MM_CLK_L : `CTS_MM_CLK_W);
                t.rd  = `CTS_MM_R2M_RD;
                t.wr  = 8'(n) * (lng ? `CTS_MM_XFR_L : `CTS_MM_XFR_W);
            end
            CLS_ADDX_MEM:  t = lng ? `CTS_ADDX_L :
                               (sz == SZ_WORD) ? `CTS_ADDX_W : `CTS_ADDX_B;
            CLS_CMPM:      t = lng ? `CTS_CMPM_L :
                               (sz == SZ_WORD) ? `CTS_CMPM_W : `CTS_CMPM_B;
            CLS_BTST_MEM:
            begin
                t  = `CTS_BTST_MEM;
                ea = 1'b1;
            end
            CLS_CHK:
            begin
                t  = `CTS_CHK;
                ea = 1'b1;
            end
            CLS_DIV_ZERO:
            begin
                t  = `CTS_DIV_ZERO;
                ea = 1'b1;
            end
            CLS_TRAP:      t = `CTS_TRAP;
            CLS_BUS_ERR:   t = `CTS_BUS_ERR;
            CLS_INTERRUPT: t = `CTS_INTERRUPT;
            CLS_RESET:     t = `CTS_RESET_SEQ;
            default:       t = '0;
        endcase
        if (ea)
        begin
            t.clk = t.clk + 16'(ea_clk);
            t.rd  = t.rd + ea_rd;
            t.wr  = t.wr + ea_wr;
        end
        return t;
    endfunction : cts_timing

    // pin level counts once second and third stage agree
    function automatic logic cts_settle(input logic [2:0] sh,
                                        input logic old);
        return (sh[1] == sh[2]) ? sh[2] : old;
    endfunction : cts_settle
endpackage : cts_pkg

// ### rtl/cts_bus_phase.sv
// four-clock bus cycle phase counter with wait insertion
`timescale 1ns/100ps
`include "cts_params.svh"
module cts_bus_phase
    import cts_pkg::*;
(
    input  wire logic clk_i,    // clock
    input  wire logic rst_i,    // async reset, high
    input  wire logic ce_i,     // clock enable
    input  wire logic en_i,     // bus cycles running
    input  wire logic wait_i,   // settled wait request
    output logic      last_o,   // final phase of a bus cycle
    output logic      wait_o    // one wait clock inserted
);
    logic [1:0] ph_reg;
    logic [1:0] ph_next;
    logic [2:0] span_reg;
    logic [2:0] span_next;
    logic       waited_reg;
    logic       waited_next;

    always_comb
    begin
        wait_o      = en_i && ph_reg == 2'(`CTS_WAIT_PHASE) && wait_i;
        last_o      = en_i && ph_reg == 2'(`CTS_BUS_CLKS - 1);
        ph_next     = ph_reg;
        span_next   = span_reg;
        waited_next = waited_reg;
        if (!en_i || last_o)
        begin
            ph_next     = 2'h0;
            span_next   = 3'h0;
            waited_next = 1'b0;
        end
        else if (wait_o)
        begin
            waited_next = 1'b1;
            span_next   = span_reg + 3'h1;
        end
        else
        begin
            ph_next   = ph_reg + 2'h1;
            span_next = span_reg + 3'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ph_reg     <= 2'h0;
            span_reg   <= 3'h0;
            waited_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            ph_reg     <= ph_next;
            span_reg   <= span_next;
            waited_reg <= waited_next;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    bus_four_clk_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (last_o && ce_i && !waited_reg) |-> span_reg == 3'h3)
        else $error("bus cycle not four clocks");
endmodule : cts_bus_phase

// ### rtl/cts_sequencer.sv
// instruction and exception timing sequencer top
`timescale 1ns/100ps
`include "cts_params.svh"
module cts_sequencer
    import cts_pkg::*;
(
    input  wire logic        CLOCK_I,       // 10 MHz clock
    input  wire logic        RST_I,         // async reset, high
    input  wire logic        CE_I,          // clock enable
    input  wire logic        START_I,       // run one class, pulse
    input  wire logic [3:0]  CLASS_I,       // instruction class
    input  wire logic [1:0]  SIZE_I,        // byte, word, long
    input  wire logic [4:0]  REG_COUNT_I,   // registers moved
    input  wire logic        INDEX_LONG_I,  // index register is long
    input  wire logic [7:0]  EA_CLK_I,      // address calc clocks
    input  wire logic [7:0]  EA_RD_I,       // address calc reads
    input  wire logic [7:0]  EA_WR_I,       // address calc writes
    input  wire logic        RESET_N_I,     // reset pin, low active
    input  wire logic        HALT_N_I,      // halt pin, low active
    input  wire logic        BUS_WAIT_I,    // wait state request pin
    output logic             READY_O,       // executing instructions
    output logic             BUSY_O,        // sequence running
    output logic             DONE_O,        // sequence ended, pulse
    output logic [15:0]      TOTAL_CLK_O,   // clocks incl. waits
    output logic [7:0]       READS_O,       // bus reads
    output logic [7:0]       WRITES_O,      // bus writes
    output logic             BUS_RD_O,      // read cycle running
    output logic             BUS_WR_O       // write cycle running
);
    typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_INT} cts_state_e;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] rst_sh_reg, halt_sh_reg, wait_sh_reg;
    logic [2:0] rst_sh_next, halt_sh_next, wait_sh_next;
    logic       rst_ok_reg, halt_ok_reg, wait_reg;
    logic       rst_ok_next, halt_ok_next, wait_next;

    always_comb
    begin
        rst_sh_next  = {rst_sh_reg[1:0], RESET_N_I};
        halt_sh_next = {halt_sh_reg[1:0], HALT_N_I};
        wait_sh_next = {wait_sh_reg[1:0], BUS_WAIT_I};
        rst_ok_next  = cts_settle(rst_sh_reg, rst_ok_reg);
        halt_ok_next = cts_settle(halt_sh_reg, halt_ok_reg);
        wait_next    = cts_settle(wait_sh_reg, wait_reg);
    end

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rst_sh_reg  <= 3'h0;
            halt_sh_reg <= 3'h0;
            wait_sh_reg <= 3'h0;
            rst_ok_reg  <= 1'b0;
            halt_ok_reg <= 1'b0;
            wait_reg    <= 1'b0;
        end
        else if (CE_I)
        begin
            rst_sh_reg  <= rst_sh_next;
            halt_sh_reg <= halt_sh_next;
            wait_sh_reg <= wait_sh_next;
            rst_ok_reg  <= rst_ok_next;
            halt_ok_reg <= halt_ok_next;
            wait_reg    <= wait_next;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    cts_state_e  state_reg, state_next;
    cts_class_e  cls_reg, cls_next, cls_sel;
    cts_tim_s    tim;
    logic [7:0]  rd_left_reg, rd_left_next, wr_left_reg, wr_left_next;
    logic [15:0] int_left_reg, int_left_next, bus_clks;
    logic [15:0] exp_clk_reg, exp_clk_next, wait_cnt_reg, wait_cnt_next;
    logic [7:0]  exp_rd_reg, exp_rd_next, exp_wr_reg, exp_wr_next;
    logic        pend_reg, pend_next, ready_next, busy_next, done_next;
    logic [15:0] total_next;
    logic [7:0]  reads_next, writes_next;
    logic        bus_rd_next, bus_wr_next;
    logic        launch, accept, finish, bus_last, bus_wait;

    cts_bus_phase u_phase (
        .clk_i  (CLOCK_I),
        .rst_i  (RST_I),
        .ce_i   (CE_I),
        .en_i   (state_reg == ST_BUS),
        .wait_i (wait_reg),
        .last_o (bus_last),
        .wait_o (bus_wait)
    );

    always_comb
    begin
        launch  = pend_reg && rst_ok_reg && halt_ok_reg;
        accept  = state_reg == ST_IDLE && (launch || (START_I && READY_O));
        cls_sel = launch ? CLS_RESET : cts_class_e'(CLASS_I);
        tim     = cts_timing(cls_sel, cts_size_e'(SIZE_I), REG_COUNT_I,
                             INDEX_LONG_I, EA_CLK_I, EA_RD_I, EA_WR_I);
        bus_clks = 16'(`CTS_BUS_CLKS) * (16'(tim.rd) + 16'(tim.wr));
        state_next    = state_reg;
        cls_next      = cls_reg;
        rd_left_next  = rd_left_reg;
        wr_left_next  = wr_left_reg;
        int_left_next = int_left_reg;
        exp_clk_next  = exp_clk_reg;
        exp_rd_next   = exp_rd_reg;
        exp_wr_next   = exp_wr_reg;
        wait_cnt_next = wait_cnt_reg + 16'(bus_wait);
        pend_next     = pend_reg;
        ready_next    = READY_O;
        finish        = 1'b0;
        case (state_reg)
            ST_IDLE:
                if (accept)
                begin
                    cls_next      = cls_sel;
                    exp_clk_next  = tim.clk;
                    exp_rd_next   = tim.rd;
                    exp_wr_next   = tim.wr;
                    rd_left_next  = tim.rd;
                    wr_left_next  = tim.wr;
                    int_left_next = (tim.clk > bus_clks)
                                  ? tim.clk - bus_clks : 16'h0;
                    wait_cnt_next = 16'h0;
                    pend_next     = 1'b0;
                    state_next    = (tim.rd != 8'h0 || tim.wr != 8'h0)
                                  ? ST_BUS : ST_INT;
                end
            ST_BUS:
                if (bus_last)
                begin
                    if (rd_left_reg != 8'h0)
                        rd_left_next = rd_left_reg - 8'h1;
                    else
                        wr_left_next = wr_left_reg - 8'h1;
                    if (16'(rd_left_reg) + 16'(wr_left_reg) == 16'h1)
                    begin
                        finish     = int_left_reg == 16'h0;
                        state_next = finish ? ST_IDLE : ST_INT;
                    end
                end
            ST_INT:
            begin
                int_left_next = int_left_reg - 16'h1;
                if (int_left_reg <= 16'h1)
                begin
                    finish     = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (finish && cls_reg == CLS_RESET)
            ready_next = 1'b1;
        if (!rst_ok_reg)
        begin
            state_next = ST_IDLE;
            pend_next  = 1'b1;
            ready_next = 1'b0;
            finish     = 1'b0;
        end
        done_next   = finish;
        total_next  = finish ? exp_clk_reg + wait_cnt_reg : TOTAL_CLK_O;
        reads_next  = finish ? exp_rd_reg : READS_O;
        writes_next = finish ? exp_wr_reg : WRITES_O;
        busy_next   = state_next != ST_IDLE;
        bus_rd_next = state_next == ST_BUS && rd_left_next != 8'h0;
        bus_wr_next = state_next == ST_BUS && rd_left_next == 8'h0;
    end

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_reg    <= ST_IDLE;
            cls_reg      <= CLS_NOP;
            rd_left_reg  <= 8'h0;
            wr_left_reg  <= 8'h0;
            int_left_reg <= 16'h0;
            exp_clk_reg  <= 16'h0;
            exp_rd_reg   <= 8'h0;
            exp_wr_reg   <= 8'h0;
            wait_cnt_reg <= 16'h0;
            pend_reg     <= 1'b1;
            READY_O      <= 1'b0;
            BUSY_O       <= 1'b0;
            DONE_O       <= 1'b0;
            TOTAL_CLK_O  <= 16'h0;
            READS_O      <= 8'h0;
            WRITES_O     <= 8'h0;
            BUS_RD_O     <= 1'b0;
            BUS_WR_O     <= 1'b0;
        end
        else if (CE_I)
        begin
            state_reg    <= state_next;
            cls_reg      <= cls_next;
            rd_left_reg  <= rd_left_next;
            wr_left_reg  <= wr_left_next;
            int_left_reg <= int_left_next;
            exp_clk_reg  <= exp_clk_next;
            exp_rd_reg   <= exp_rd_next;
            exp_wr_reg   <= exp_wr_next;
            wait_cnt_reg <= wait_cnt_next;
            pend_reg     <= pend_next;
            READY_O      <= ready_next;
            BUSY_O       <= busy_next;
            DONE_O       <= done_next;
            TOTAL_CLK_O  <= total_next;
            READS_O      <= reads_next;
            WRITES_O     <= writes_next;
            BUS_RD_O     <= bus_rd_next;
            BUS_WR_O     <= bus_wr_next;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [15:0] rd_cyc_reg, wr_cyc_reg;
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rd_cyc_reg <= 16'h0;
            wr_cyc_reg <= 16'h0;
        end
        else if (CE_I)
        begin
            rd_cyc_reg <= accept ? 16'h0 : rd_cyc_reg + 16'(BUS_RD_O);
            wr_cyc_reg <= accept ? 16'h0 : wr_cyc_reg + 16'(BUS_WR_O);
        end
    end

    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    rw_pair_a: assert property (
        DONE_O && wait_cnt_reg == 16'h0 |->
        rd_cyc_reg == {6'h0, READS_O, 2'h0} &&
        wr_cyc_reg == {6'h0, WRITES_O, 2'h0})
        else $error("bus cycles disagree with counts");
    ea_addon_a: assert property (
        accept && cls_sel == CLS_CHK && CE_I |=>
        exp_clk_reg == 16'h0044 + 16'($past(EA_CLK_I)) &&
        exp_wr_reg == 8'h06 + $past(EA_WR_I))
        else $error("address calc not added");
    multi_prec_a: assert property (
        accept && cls_sel == CLS_ADDX_MEM && SIZE_I == 2'h2 && CE_I |=>
        exp_clk_reg == 16'h003a && exp_rd_reg == 8'h0a && exp_wr_reg == 8'h04)
        else $error("multi-precision figure wrong");
    move_multiple_registers_per_reg_a: assert property (
        accept && cls_sel == CLS_MOVE_MULTIPLE_REGISTERS_M2R && SIZE_I == 2'h1 && CE_I |=>
        exp_clk_reg == 16'h0018 + 16'h0008 * 16'($past(REG_COUNT_I)))
        else $error("register block move time wrong");
    index_size_a: assert property (
        accept |-> cts_timing(cls_sel, cts_size_e'(SIZE_I), REG_COUNT_I,
            1'b0, EA_CLK_I, EA_RD_I, EA_WR_I) == tim)
        else $error("index size changed timing");
    bus_err_a: assert property (
        DONE_O && cls_reg == CLS_BUS_ERR && wait_cnt_reg == 16'h0 |->
        TOTAL_CLK_O == 16'h005e && READS_O == 8'h08 && WRITES_O == 8'h0e)
        else $error("exception figure wrong");
    intr_time_a: assert property (
        DONE_O && cls_reg == CLS_INTERRUPT && wait_cnt_reg == 16'h0 |->
        TOTAL_CLK_O == 16'h0048 && READS_O == 8'h09 && WRITES_O == 8'h10)
        else $error("interrupt figure wrong");
    reset_seq_a: assert property (
        $rose(READY_O) |-> DONE_O && READS_O == 8'h0c && WRITES_O == 8'h0
        && TOTAL_CLK_O == 16'h0040 + wait_cnt_reg)
        else $error("reset sequence figure wrong");
    wait_stretch_a: assert property (
        bus_wait && CE_I |=> wait_cnt_reg == $past(wait_cnt_reg) + 16'h1)
        else $error("wait state not counted");

    reset_seen_c: cover property ($rose(READY_O));
    move_multiple_registers_run_c:  cover property (DONE_O && cls_reg == CLS_MOVE_MULTIPLE_REGISTERS_R2M);
    intr_run_c:   cover property (DONE_O && cls_reg == CLS_INTERRUPT);
    wait_run_c:   cover property (DONE_O && wait_cnt_reg != 16'h0);
endmodule : cts_sequencer

// ### bench/cts_bus_model.sv
// memory and peripheral partner answering the sequencer bus cycles
`timescale 1ns/100ps
module cts_bus_model
(
    input  wire logic clk_i,   // clock
    input  wire logic rd_i,    // read cycle running
    input  wire logic wr_i,    // write cycle running
    input  wire logic slow_i,  // answer with wait states
    output logic      wait_o   // wait state request
);
    // ------------------------------------------------------------
    // answer timing
    // ------------------------------------------------------------
    logic [2:0] cnt_reg = 3'h0;

    always @(posedge clk_i)
        cnt_reg <= (rd_i | wr_i) ? cnt_reg + 3'h1 : 3'h0;

    // prompt mode keeps every cycle, acknowledge too, at four clocks
    assign wait_o = slow_i & (rd_i | wr_i)
                  & (cnt_reg < 3'h3);
endmodule : cts_bus_model

// ### bench/tb_cpu_instruction_timing_sequencer.sv
// self-checking bench of the instruction timing sequencer
`timescale 1ns/100ps
module tb_cpu_instruction_timing_sequencer
    import cts_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        start = 1'b0;
    logic        idx = 1'b0;
    logic        rn = 1'b1;
    logic        hn = 1'b0;
    logic        slow = 1'b0;
    logic        wt;
    logic [3:0]  cls = 4'h0;
    logic [1:0]  sz = 2'h0;
    logic [4:0]  n = 5'h00;
    logic [7:0]  ec = 8'h00;
    logic [7:0]  er = 8'h00;
    logic [7:0]  ew = 8'h00;
    logic        ready;
    logic        busy;
    logic        done;
    logic [15:0] tot;
    logic [7:0]  rds;
    logic [7:0]  wrs;
    logic        brd;
    logic        bwr;
    logic [15:0] rd_cyc = 16'h0000;
    logic [15:0] wr_cyc = 16'h0000;
    cts_tim_s    q[$];
    bit          sq[$];
    int          miscompares = 0;
    int          num_checks = 0;

    always #50 clk = ~clk;

    cts_sequencer u_cts_sequencer (.CLOCK_I(clk), .RST_I(rst), .CE_I(ce),
        .START_I(start), .CLASS_I(cls), .SIZE_I(sz), .REG_COUNT_I(n),
        .INDEX_LONG_I(idx), .EA_CLK_I(ec), .EA_RD_I(er), .EA_WR_I(ew),
        .RESET_N_I(rn), .HALT_N_I(hn), .BUS_WAIT_I(wt), .READY_O(ready),
        .BUSY_O(busy), .DONE_O(done), .TOTAL_CLK_O(tot), .READS_O(rds),
        .WRITES_O(wrs), .BUS_RD_O(brd), .BUS_WR_O(bwr));

    cts_bus_model u_cts_bus_model (.clk_i(clk), .rd_i(brd), .wr_i(bwr),
        .slow_i(slow), .wait_o(wt));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk_clk(input string nm, input logic [15:0] ex,
                           input logic [15:0] got);
        num_checks++;
        if (got !== ex)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk_clk

    task automatic chk_cnt(input string nm, input logic [7:0] ex,
                           input logic [7:0] got);
        chk_clk(nm, {8'h00, ex}, {8'h00, got});
    endtask : chk_cnt

    function automatic cts_tim_s fig(input logic [3:0] c, input logic [1:0] s,
                                     input logic [4:0] r, input logic [7:0] a,
                                     input logic [7:0] b, input logic [7:0] w);
        cts_tim_s    t;
        logic [7:0]  k;
        logic [15:0] mc;
        k  = (s == 2'h2) ? 8'h04 : 8'h02;
        mc = (16'(k) * 16'(r)) << 2;
        case (c)
            4'h0: t = {16'h0008, 8'h02, 8'h00};
            4'h1: t = {16'h0018 + mc, 8'h06 + k * 8'(r), 8'h00};
            4'h2: t = {16'h0010 + mc, 8'h04, k * 8'(r)};
            4'h3: t = (s == 2'h0) ? {16'h0016, 8'h04, 8'h01} :
                      (s == 2'h1) ? {16'h0032, 8'h06, 8'h02} :
                                    {16'h003a, 8'h0a, 8'h04};
            4'h4: t = (s == 2'h0) ? {16'h0010, 8'h04, 8'h00} :
                      (s == 2'h1) ? {16'h0018, 8'h06, 8'h00} :
                                    {16'h0028, 8'h0a, 8'h00};
            4'h5: t = {16'h0008 + 16'(a), 8'h02 + b, w};
            4'h6: t = {16'h0044 + 16'(a), 8'h08 + b, 8'h06 + w};
            4'h7: t = {16'h0042 + 16'(a), 8'h08 + b, 8'h06 + w};
            4'h8: t = {16'h003e, 8'h08, 8'h06};
            4'h9: t = {16'h005e, 8'h08, 8'h0e};
            4'ha: t = {16'h0048, 8'h09, 8'h10};
            default: t = {16'h0040, 8'h0c, 8'h00};
        endcase
        return t;
    endfunction : fig

    task automatic wait_idle;
        int k;
        k = 0;
        while (!(ready === 1'b1 && busy === 1'b0) && k < 3000)
        begin
            @(posedge clk);
            #10;
            k++;
        end
        if (k >= 3000)
            miscompares++;
    endtask : wait_idle

    task automatic launch(input logic [3:0] c, input logic [1:0] s,
                          input bit sl, input logic ix);
        wait_idle();
        cls   = c;
        sz    = s;
        idx   = ix;
        slow  = sl;
        n     = 5'($urandom_range(31));
        ec    = 8'($urandom_range(15));
        er    = 8'($urandom_range(3));
        ew    = 8'($urandom_range(3));
        start = 1'b1;
        q.push_back(fig(c, s, n, ec, er, ew));
        sq.push_back(sl);
        @(posedge clk);
        #10;
        start = 1'b0;
    endtask : launch

    // ------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------
    always @(negedge clk)
    begin
        cts_tim_s    e;
        bit          sl;
        logic [15:0] ex;
        if (brd === 1'b1)
            rd_cyc++;
        if (bwr === 1'b1)
            wr_cyc++;
        if (done === 1'b1)
        begin
            if (q.size() == 0)
                chk_cnt("DONE_O", 8'h00, 8'h01);
            else
            begin
                e  = q.pop_front();
                sl = sq.pop_front();
                ex = e.clk;
                if (sl)
                    ex = ex + rd_cyc + wr_cyc - ((16'(e.rd) + 16'(e.wr)) << 2);
                else
                begin
                    chk_clk("read clocks", 16'(e.rd) << 2, rd_cyc);
                    chk_clk("write clocks", 16'(e.wr) << 2, wr_cyc);
                end
                chk_clk("TOTAL_CLK_O", ex, tot);
                chk_cnt("READS_O", e.rd, rds);
                chk_cnt("WRITES_O", e.wr, wrs);
            end
            rd_cyc = 16'h0000;
            wr_cyc = 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        #(60000 * 100);
        miscompares++;
        end_sim();
    end

    initial
    begin
        void'($urandom(74));
        repeat (2) @(posedge clk);
        #10;
        rst = 1'b0;
        repeat (100) @(posedge clk);
        #10;
        chk_cnt("READY_O", 8'h00, {7'h00, ready});
        q.push_back({16'h0040, 8'h0c, 8'h00});
        sq.push_back(1'b0);
        hn = 1'b1;
        for (int c = 0; c < 12; c++)
            for (int s = 0; s < 3; s++)
                launch(4'(c), 2'(s), 1'b0,
                       1'($urandom_range(1)));
        launch(4'h6, 2'h0, 1'b0, 1'b0);
        launch(4'h6, 2'h0, 1'b0, 1'b1);
        repeat (12)
            launch(4'($urandom_range(10)), 2'($urandom_range(2)),
                   1'b1, 1'b0);
        launch(4'h0, 2'h0, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        #10;
        start = 1'b1;
        cls   = 4'ha;
        @(posedge clk);
        #10;
        start = 1'b0;
        wait_idle();
        @(posedge clk);
        #10;
        ce    = 1'b0;
        start = 1'b1;
        repeat (3) @(posedge clk);
        #10;
        start = 1'b0;
        ce    = 1'b1;
        launch(4'h1, 2'h2, 1'b0, 1'b0);
        repeat (5) @(posedge clk);
        #10;
        rn = 1'b0;
        void'(q.pop_back());
        void'(sq.pop_back());
        repeat (10) @(posedge clk);
        #10;
        chk_cnt("READY_O", 8'h00, {7'h00, ready});
        rd_cyc = 16'h0000;
        wr_cyc = 16'h0000;
        q.push_back({16'h0040, 8'h0c, 8'h00});
        sq.push_back(1'b0);
        rn = 1'b1;
        launch(4'ha, 2'h0, 1'b0, 1'b0);
        wait_idle();
        repeat (2) @(posedge clk);
        #10;
        chk_cnt("pending results", 8'h00, 8'(q.size()));
        end_sim();
    end
endmodule : tb_cpu_instruction_timing_sequencer
